// ===== litebus_defs.svh
`ifndef LITEBUS_DEFS_SVH
`define LITEBUS_DEFS_SVH

// Response codes, two bits wide
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
`define RESP_DECERR  2'h3
// Implied attributes of every access
`define CACHE_ATTR   4'h0
`define LOCK_ATTR    1'h0
`define BURST_BEATS  1
// Default geometry
`define DATA_W_DEF   32
`define ADDR_W_DEF   12
`define ID_W_DEF     4
`define MEM_WORDS_DEF 64

`endif

// ===== litebus_pkg.sv
package litebus_pkg;
    // Slave write-strobe policy
    typedef enum logic [1:0] {
        STRB_HONOUR = 2'h0,
        STRB_IGNORE = 2'h1,
        STRB_ERROR  = 2'h3
    } strb_policy_t;

    // Master sequencing state, Gray from M_IDLE to M_ADDR to M_RESP, two bits change back to M_IDLE
    typedef enum logic [1:0] {
        M_IDLE = 2'h0,
        M_ADDR = 2'h1,
        M_RESP = 2'h3
    } mstate_t;
endpackage

// ===== litebus_if.sv
`timescale 1ns/1ps
`include "litebus_defs.svh"
interface litebus_if #(
    parameter int DATA_W = `DATA_W_DEF,
    parameter int ADDR_W = `ADDR_W_DEF,
    parameter int ID_W   = `ID_W_DEF
) (
    input wire logic CLK,
    input wire logic RST_N
);
    // Write address channel
    logic              awvalid;
    logic              awready;
    logic [ADDR_W-1:0] awaddr;
    logic [2:0]        awprot;
    logic [ID_W-1:0]   awid;
    // Write data channel
    logic              wvalid;
    logic              wready;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W/8-1:0] wstrb;
    // Write response channel
    logic              bvalid;
    logic              bready;
    logic [1:0]        bresp;
    logic [ID_W-1:0]   bid;
    // Read address channel
    logic              arvalid;
    logic              arready;
    logic [ADDR_W-1:0] araddr;
    logic [2:0]        arprot;
    logic [ID_W-1:0]   arid;
    // Read data channel
    logic              rvalid;
    logic              rready;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
    logic [ID_W-1:0]   rid;

    modport slave (
        input  CLK, RST_N,
        input  awvalid, awaddr, awprot, awid, wvalid, wdata, wstrb, bready,
        input  arvalid, araddr, arprot, arid, rready,
        output awready, wready, bvalid, bresp, bid, arready, rvalid, rdata, rresp, rid
    );
    modport master (
        input  CLK, RST_N,
        output awvalid, awaddr, awprot, awid, wvalid, wdata, wstrb, bready,
        output arvalid, araddr, arprot, arid, rready,
        input  awready, wready, bvalid, bresp, bid, arready, rvalid, rdata, rresp, rid
    );
endinterface

// ===== litebus_strb_check.sv
`timescale 1ns/1ps
`include "litebus_defs.svh"
// Judges a strobe pattern against the slave's write policy
module litebus_strb_check #(
    parameter int DATA_W = `DATA_W_DEF,
    parameter litebus_pkg::strb_policy_t POLICY = litebus_pkg::STRB_HONOUR
) (
    // Strobe under test
    input  wire logic [DATA_W/8-1:0] strb,
    // Verdict
    output logic                     refuse,
    output logic [DATA_W/8-1:0]      lanes,
    output logic                     empty
);
    // Width check
    initial
    begin
        if (DATA_W != 32 && DATA_W != 64)
            $error("litebus_strb_check: data width must be 32 or 64");
    end

    // Whole 32-bit halves are the only patterns a limited slave serves
    function automatic logic whole_halves(input logic [DATA_W/8-1:0] s);
        logic ok;
        ok = 1'b1;
        for (int h = 0; h < DATA_W / 32; h++)
        begin
            if (s[h*4 +: 4] != 4'h0 && s[h*4 +: 4] != 4'hf)
                ok = 1'b0;
        end
        return ok;
    endfunction

    // Lane selection and refusal per policy
    always_comb
    begin
        empty  = (strb == '0);
        refuse = 1'b0;
        lanes  = strb;
        case (POLICY)
            litebus_pkg::STRB_IGNORE: lanes = '1;
            litebus_pkg::STRB_ERROR:  refuse = !whole_halves(strb);
            default:                  lanes = strb;
        endcase
    end
endmodule

// ===== litebus_slave.sv
`timescale 1ns/1ps
`include "litebus_defs.svh"
// How it works
// - Each transaction moves exactly one beat
// - Data width fixed at 32 or 64
// - Accesses are non-modifiable, non-bufferable
// - Normal access only, no exclusives
// - Never answer with exclusive-okay code
// - Clock, reset and five handshake channels
// - Every single beat is the last
// - Wide slave sees full-width transactions always
// - Narrow-master registers use low half
// - Masters present correct byte strobes
// - Pick one strobe policy: honour, ignore, error
// - Memory slave applies byte and halfword strobes
// - Empty-strobe writes allowed, suppression optional
// - Ready low limits outstanding transactions
// - Responses return in issue order
// - No interleaving of data beats
// - Reflect captured address identifier in response
// - Adapter needed for unrestricted full masters
// - Write identifier taken from write address
module litebus_slave #(
    parameter int DATA_W    = `DATA_W_DEF,
    parameter int ADDR_W    = `ADDR_W_DEF,
    parameter int ID_W      = `ID_W_DEF,
    parameter int MEM_WORDS = `MEM_WORDS_DEF,
    parameter litebus_pkg::strb_policy_t POLICY = litebus_pkg::STRB_HONOUR
) (
    // Bus side
    litebus_if.slave bus,
    // Status
    output logic     WR_DONE,
    output logic     RD_DONE
);
    // Byte-lane address bits and word-index bits
    localparam int SB  = $clog2(DATA_W / 8);
    localparam int IXW = $clog2(MEM_WORDS);

    // Geometry check
    initial
    begin
        if ((DATA_W != 32 && DATA_W != 64) || MEM_WORDS < 2 || (MEM_WORDS & (MEM_WORDS - 1)) != 0
            || ADDR_W < IXW + SB
            || ID_W < 1)
            $error("litebus_slave: unsupported geometry");
    end

    // Storage; not reset, undefined until written
    logic [DATA_W-1:0] mem [MEM_WORDS];

    // Whole slave state: write holding slot, response and read answer
    typedef struct packed {
        logic              aw_full;
        logic [ADDR_W-1:0] aw_addr;
        logic [ID_W-1:0]   aw_id;
        logic              w_full;
        logic [DATA_W-1:0] w_data;
        logic [DATA_W/8-1:0] w_strb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic [ID_W-1:0]   bid;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [ID_W-1:0]   rid;
        logic [DATA_W-1:0] rdata;
        logic              wr_done;
        logic              rd_done;
    } sstate_t;

    // Registered state and its next value
    sstate_t s;
    sstate_t next_s;

    // Strobe verdict and write qualifiers
    logic                refuse;
    logic                empty;
    logic [DATA_W/8-1:0] lanes;
    logic                do_write;
    logic                mem_we;

    // Strobe judgement on the held beat
    litebus_strb_check #(
        .DATA_W (DATA_W),
        .POLICY (POLICY)
    ) u_litebus_strb_check (
        .strb   (s.w_strb),
        .refuse (refuse),
        .lanes  (lanes),
        .empty  (empty)
    );

    // Word index; low byte-lane bits are ignored
    function automatic logic [IXW-1:0] word_ix(input logic [ADDR_W-1:0] a);
        return a[SB +: IXW];
    endfunction

    // Out of range addresses decode-error
    function automatic logic in_range(input logic [ADDR_W-1:0] a);
        return (a >> (SB + IXW)) == '0;
    endfunction

    // One write in flight: execute when both halves are held and response slot is free
    assign do_write = s.aw_full && s.w_full && !s.bvalid;
    assign mem_we   = do_write && in_range(s.aw_addr) && !refuse && !empty;

    // Next-state logic
    always_comb
    begin
        next_s         = s;
        next_s.wr_done = 1'b0;
        next_s.rd_done = 1'b0;
        // Capture address and data separately; every beat is final
        if (bus.awvalid && !s.aw_full)
        begin
            next_s.aw_full = 1'b1;
            next_s.aw_addr = bus.awaddr;
            next_s.aw_id   = bus.awid;
        end
        if (bus.wvalid && !s.w_full)
        begin
            next_s.w_full = 1'b1;
            next_s.w_data = bus.wdata;
            next_s.w_strb = bus.wstrb;
        end

        // Response retires on handshake
        if (s.bvalid && bus.bready)
            next_s.bvalid = 1'b0;

        // Execute the held write and raise its response
        if (do_write)
        begin
            next_s.aw_full = 1'b0;
            next_s.w_full  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bid     = s.aw_id;
            next_s.wr_done = 1'b1;
            if (!in_range(s.aw_addr))
                next_s.bresp = `RESP_DECERR;
            else if (refuse)
                next_s.bresp = `RESP_SLVERR;
            else
                next_s.bresp = `RESP_OKAY;
        end

        // Read: one at a time, answered next cycle, so order is kept
        if (s.rvalid && bus.rready)
            next_s.rvalid = 1'b0;
        if (bus.arvalid && !s.rvalid)
        begin
            next_s.rvalid  = 1'b1;
            next_s.rid     = bus.arid;
            next_s.rd_done = 1'b1;
            if (in_range(bus.araddr))
            begin
                next_s.rdata = mem[word_ix(bus.araddr)];
                next_s.rresp = `RESP_OKAY;
            end
            else
            begin
                // Out of range: zero data, decode error
                next_s.rdata = '0;
                next_s.rresp = `RESP_DECERR;
            end
        end

        // Attributes not carried are implied constant
        if (`CACHE_ATTR != 4'h0 || `LOCK_ATTR != 1'h0)
            next_s.bresp = `RESP_SLVERR;
    end

    // State register with synchronous reset
    always_ff @(posedge bus.CLK)
    begin
        if (!bus.RST_N)
            s <= '0;
        else
            s <= next_s;
    end

    // Byte-lane memory update
    always_ff @(posedge bus.CLK)
    begin
        if (mem_we)
        begin
            for (int b = 0; b < DATA_W / 8; b++)
            begin
                if (lanes[b])
                    mem[word_ix(s.aw_addr)][b*8 +: 8] <= s.w_data[b*8 +: 8];
            end
        end
    end

    // Ready means the holding slot is empty; valids held until taken
    assign bus.awready = !s.aw_full;
    assign bus.wready  = !s.w_full;
    assign bus.arready = !s.rvalid;

    // Responses straight from the state register
    assign bus.bvalid  = s.bvalid;
    assign bus.bresp   = s.bresp;
    assign bus.bid     = s.bid;
    assign bus.rvalid  = s.rvalid;
    assign bus.rresp   = s.rresp;
    assign bus.rid     = s.rid;
    assign bus.rdata   = s.rdata;

    // Status pulses
    assign WR_DONE     = s.wr_done;
    assign RD_DONE     = s.rd_done;
endmodule

// ===== litebus_master.sv
`timescale 1ns/1ps
`include "litebus_defs.svh"
// Issues one single-beat read or write per user request
module litebus_master #(
    parameter int DATA_W = `DATA_W_DEF,
    parameter int ADDR_W = `ADDR_W_DEF,
    parameter int ID_W   = `ID_W_DEF
) (
    // Bus side
    litebus_if.master            bus,
    // User request
    input  wire logic            REQ,
    input  wire logic            REQ_WRITE,
    input  wire logic [ADDR_W-1:0] REQ_ADDR,
    input  wire logic [DATA_W-1:0] REQ_WDATA,
    input  wire logic [DATA_W/8-1:0] REQ_STRB,
    input  wire logic [2:0]      REQ_PROT,
    // User answer
    output logic                 BUSY,
    output logic                 DONE,
    output logic [DATA_W-1:0]    RDATA,
    output logic [1:0]           RESP
);
    // Width check
    initial
    begin
        if (DATA_W != 32 && DATA_W != 64)
            $error("litebus_master: data width must be 32 or 64");
    end

    typedef struct packed {
        litebus_pkg::mstate_t st;
        logic                write;
        logic                aw_pend;
        logic                w_pend;
        logic                ar_pend;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
        logic [DATA_W/8-1:0] strb;
        logic [2:0]          prot;
        logic                done;
        logic [DATA_W-1:0]   rdata;
        logic [1:0]          resp;
        logic [ID_W-1:0]     tag;
    } mstate_reg_t;

    mstate_reg_t m;
    mstate_reg_t next_m;

    // Sequencing
    always_comb
    begin
        next_m      = m;
        next_m.done = 1'b0;
        case (m.st)
            litebus_pkg::M_IDLE:
            begin
                if (REQ)
                begin
                    next_m.st      = litebus_pkg::M_ADDR;
                    next_m.write   = REQ_WRITE;
                    next_m.aw_pend = REQ_WRITE;
                    next_m.w_pend  = REQ_WRITE;
                    next_m.ar_pend = !REQ_WRITE;
                    next_m.addr    = REQ_ADDR;
                    next_m.wdata   = REQ_WDATA;
                    next_m.strb    = REQ_STRB;
                    next_m.prot    = REQ_PROT;
                    next_m.tag     = m.tag + 1'b1;
                end
            end
            litebus_pkg::M_ADDR:
            begin
                // Valids drop only after their handshakes
                if (bus.awready)
                    next_m.aw_pend = 1'b0;
                if (bus.wready)
                    next_m.w_pend = 1'b0;
                if (bus.arready)
                    next_m.ar_pend = 1'b0;
                if ((!m.aw_pend || bus.awready) && (!m.w_pend || bus.wready) && (!m.ar_pend || bus.arready))
                    next_m.st = litebus_pkg::M_RESP;
            end
            litebus_pkg::M_RESP:
            begin
                if (m.write && bus.bvalid)
                begin
                    next_m.st   = litebus_pkg::M_IDLE;
                    next_m.resp = bus.bresp;
                    next_m.done = 1'b1;
                end
                else if (!m.write && bus.rvalid)
                begin
                    next_m.st    = litebus_pkg::M_IDLE;
                    next_m.resp  = bus.rresp;
                    next_m.rdata = bus.rdata;
                    next_m.done  = 1'b1;
                end
            end
            default: next_m.st = litebus_pkg::M_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge bus.CLK)
    begin
        if (!bus.RST_N)
            m <= '0;
        else
            m <= next_m;
    end

    // Bus drive; single beat, one transaction at a time
    assign bus.awvalid = (m.st == litebus_pkg::M_ADDR) && m.aw_pend;
    assign bus.wvalid  = (m.st == litebus_pkg::M_ADDR) && m.w_pend;
    assign bus.arvalid = (m.st == litebus_pkg::M_ADDR) && m.ar_pend;
    assign bus.awaddr  = m.addr;
    assign bus.araddr  = m.addr;
    assign bus.awprot  = m.prot;
    assign bus.arprot  = m.prot;
    // Fresh identifier per transaction so the slave's reflection shows
    assign bus.awid    = m.tag;
    assign bus.arid    = m.tag;
    assign bus.wdata   = m.wdata;
    assign bus.wstrb   = m.strb;
    assign bus.bready  = (m.st == litebus_pkg::M_RESP) && m.write;
    assign bus.rready  = (m.st == litebus_pkg::M_RESP) && !m.write;
    assign BUSY        = (m.st != litebus_pkg::M_IDLE);
    assign DONE        = m.done;
    assign RDATA       = m.rdata;
    assign RESP        = m.resp;
endmodule

// ===== litebus_properties.sv
`timescale 1ns/1ps
module litebus_properties #(
    parameter int DATA_W = 32,
    parameter int ADDR_W = 12,
    parameter int ID_W   = 4
) (
    // Global
    input wire logic              CLK,
    input wire logic              RST_N,
    // Write side
    input wire logic              awvalid,
    input wire logic              awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [ID_W-1:0]   awid,
    input wire logic              wvalid,
    input wire logic              wready,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic              bvalid,
    input wire logic              bready,
    input wire logic [1:0]        bresp,
    input wire logic [ID_W-1:0]   bid,
    // Read side
    input wire logic              arvalid,
    input wire logic              arready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [ID_W-1:0]   arid,
    input wire logic              rvalid,
    input wire logic              rready,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic [1:0]        rresp,
    input wire logic [ID_W-1:0]   rid
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    // Both write halves taken at one edge
    sequence wr_taken;
        awvalid && awready && wvalid && wready;
    endsequence
    // Read address taken
    sequence rd_taken;
        arvalid && arready;
    endsequence

    aw_hold_a: assert property (awvalid && !awready |=> awvalid && $stable(awaddr) && $stable(awid))
        else $error("write address dropped early");
    w_hold_a: assert property (wvalid && !wready |=> wvalid && $stable(wdata))
        else $error("write data dropped early");
    ar_hold_a: assert property (arvalid && !arready |=> arvalid && $stable(araddr))
        else $error("read address dropped early");
    b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp) && $stable(bid))
        else $error("write response dropped early");
    r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read data dropped early");
    b_code_a: assert property (bvalid |-> bresp != 2'h1)
        else $error("exclusive okay on write response");
    r_code_a: assert property (rvalid |-> rresp != 2'h1)
        else $error("exclusive okay on read data");
    reset_quiet_a: assert property (disable iff (1'b0) !RST_N |=> !bvalid && !rvalid && !awvalid && !arvalid)
        else $error("valid high after reset");
    bid_reflect_a: assert property (wr_taken |-> ##2 bvalid && bid == $past(awid, 2))
        else $error("write response late or wrong id");
    rid_reflect_a: assert property (rd_taken |=> rvalid && rid == $past(arid))
        else $error("read data late or wrong id");
    one_write_a: assert property (wr_taken |=> !awready && !wready)
        else $error("write slot still open after a write was taken");
endmodule

// ===== tb_lite_register_bus_slave.sv
`timescale 1ns/1ps
module tb_lite_register_bus_slave;
    typedef struct packed { logic wr; logic [1:0] resp; logic [31:0] data; } note_t;
    logic        CLK;
    logic        RST_N;
    logic        req;
    logic        req_write;
    logic [11:0] req_addr;
    logic [31:0] req_wdata;
    logic [3:0]  req_strb;
    logic [2:0]  req_prot;
    logic        busy;
    logic        done;
    logic [31:0] rdata;
    logic [1:0]  resp;
    logic        wr_done;
    logic        rd_done;
    logic [31:0] mem [64];
    note_t       notes [$];
    note_t       n;
    int          n_errors;
    int          tests_run;
    int          seed;
    int          k;
    int          n_wr;
    int          n_rd;
    int          n_wr_seen;
    int          n_rd_seen;

    // Free running clock
    initial
    begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end

    // Both ends joined by the interface
    litebus_if bus_if (.CLK(CLK), .RST_N(RST_N));
    litebus_slave u_litebus_slave (.bus(bus_if.slave), .WR_DONE(wr_done), .RD_DONE(rd_done));
    litebus_master u_litebus_master (
        .bus(bus_if.master), .REQ(req), .REQ_WRITE(req_write), .REQ_ADDR(req_addr),
        .REQ_WDATA(req_wdata), .REQ_STRB(req_strb), .REQ_PROT(req_prot),
        .BUSY(busy), .DONE(done), .RDATA(rdata), .RESP(resp));
    litebus_properties u_litebus_properties (
        .CLK(CLK), .RST_N(RST_N), .awvalid(bus_if.awvalid), .awready(bus_if.awready),
        .awaddr(bus_if.awaddr), .awid(bus_if.awid), .wvalid(bus_if.wvalid), .wready(bus_if.wready),
        .wdata(bus_if.wdata), .bvalid(bus_if.bvalid), .bready(bus_if.bready), .bresp(bus_if.bresp),
        .bid(bus_if.bid), .arvalid(bus_if.arvalid), .arready(bus_if.arready), .araddr(bus_if.araddr),
        .arid(bus_if.arid), .rvalid(bus_if.rvalid), .rready(bus_if.rready), .rdata(bus_if.rdata),
        .rresp(bus_if.rresp), .rid(bus_if.rid));

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Counts, verdict, end of run
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Bounded wait for an idle master
    task automatic wait_idle();
        k = 0;
        while (busy !== 1'b0 && k < 60)
        begin
            @(posedge CLK);
            #1;
            k++;
        end
        if (k == 60)
        begin
            n_errors++;
            $display("MISMATCH at %0t: master stuck", $time);
            print_verdict();
        end
    endtask

    // One request, with its expected answer noted first
    task automatic op(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        note_t e;
        e.wr = wr;
        e.resp = (a[11:8] === 4'h0) ? 2'h0 : 2'h3;
        e.data = (e.resp == 2'h0 && !wr) ? mem[a[7:2]] : 32'h0;
        if (wr && e.resp == 2'h0)
            for (int b = 0; b < 4; b++)
                if (s[b])
                    mem[a[7:2]][8*b+:8] = d[8*b+:8];
        wait_idle();
        notes.push_back(e);
        if (wr)
            n_wr++;
        else
            n_rd++;
        req = 1'b1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        req_strb = s;
        req_prot = 3'($random(seed));
        @(posedge CLK);
        #1;
        req = 1'b0;
    endtask

    // Result watcher
    always @(negedge CLK)
        if (done === 1'b1)
        begin
            if (notes.size() == 0)
                check(32'h1, 32'h0);
            else
            begin
                n = notes.pop_front();
                check({30'h0, resp}, {30'h0, n.resp});
                if (!n.wr)
                    check(rdata, n.data);
            end
        end

    // Slave status pulses, one per single-beat transaction
    always @(negedge CLK)
    begin
        if (wr_done === 1'b1)
            n_wr_seen++;
        if (rd_done === 1'b1)
            n_rd_seen++;
    end

    // Main sequence
    initial
    begin
        seed = 28;
        n_errors = 0;
        tests_run = 0;
        n_wr = 0;
        n_rd = 0;
        n_wr_seen = 0;
        n_rd_seen = 0;
        req = 1'b0;
        req_write = 1'b0;
        req_addr = 12'h0;
        req_wdata = 32'h0;
        req_strb = 4'h0;
        req_prot = 3'h0;
        RST_N = 1'b0;
        repeat (2) @(posedge CLK);
        #1;
        RST_N = 1'b1;
        for (int i = 0; i < 64; i++)
            op(1'b1, 12'(i * 4), $random(seed), 4'hf);
        $display("Test fill done");
        // Mixed traffic: partial and empty strobes, out of range places
        for (int i = 0; i < 400; i++)
            op(1'($random(seed)), {(($random(seed) & 7) == 0) ? 4'h8 : 4'h0, 8'($random(seed))},
               $random(seed), 4'($random(seed)));
        $display("Test random done");
        wait_idle();
        repeat (3) @(posedge CLK);
        check(32'(notes.size()), 32'h0);
        check(32'(n_wr_seen), 32'(n_wr));
        check(32'(n_rd_seen), 32'(n_rd));
        print_verdict();
    end
endmodule
